//--- hw/mmpio_port_io.sv
// Purpose: Memory-mapped 4-bit port logic: direction control, latches, instruction effects.
// Assumes: One 10 MHz clock; pins already synchronous; CPU operations arrive as bus commands.
// Notes:   A write to the command register executes one port instruction at once.
`timescale 1ns/1ns

module mmpio_port_io (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic [mmpio_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [mmpio_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    input  wire mmpio_pkg::mmpio_pin_in_t   pin_in,
    output mmpio_pkg::mmpio_pin_out_t       pin_out,
    output mmpio_pkg::mmpio_pin_out_t       pin_oe_n
);

    function automatic logic [3:0] port_dir(input logic [2:0] port,
                                            input logic [7:0] da,
                                            input logic [7:0] db);
        case (port)
            mmpio_pkg::PORT2: port_dir = {4{db[mmpio_pkg::DIRB_P2_BIT]}};
            mmpio_pkg::PORT3: port_dir = da[mmpio_pkg::DIRA_P3_LSB +: 4];
            mmpio_pkg::PORT5: port_dir = {4{db[mmpio_pkg::DIRB_P5_BIT]}};
            mmpio_pkg::PORT6: port_dir = da[mmpio_pkg::DIRA_P6_LSB +: 4];
            default:          port_dir = mmpio_pkg::NIB_ZERO;
        endcase
    endfunction : port_dir

    function automatic logic [1:0] slot_of(input logic [2:0] port);
        case (port)
            mmpio_pkg::PORT3: slot_of = 2'h1;
            mmpio_pkg::PORT5: slot_of = 2'h2;
            mmpio_pkg::PORT6: slot_of = 2'h3;
            default:          slot_of = 2'h0;
        endcase
    endfunction : slot_of

    logic [7:0]               dir_a;
    logic [7:0]               dir_b;
    logic [3:0]               latch [mmpio_pkg::SLOTS];
    mmpio_pkg::mmpio_result_t result_q;
    mmpio_pkg::mmpio_result_t next_result;
    logic [3:0]               next_latch;
    logic                     latch_we;

    // Write channel: address and data are taken together, one response outstanding.
    wire        wr_take   = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    wire        rd_take   = s_axi_arvalid && !s_axi_rvalid;
    wire [7:0]  wa        = s_axi_awaddr;
    wire [7:0]  ra        = s_axi_araddr;
    wire        hit_dir_a = (wa == mmpio_pkg::OFF_DIR_A);
    wire        hit_dir_b = (wa == mmpio_pkg::OFF_DIR_B);
    wire        hit_cmd   = (wa == mmpio_pkg::OFF_CMD);
    wire        wa_ro     = (wa == mmpio_pkg::OFF_RESULT) || (wa == mmpio_pkg::OFF_LATCH) ||
                            (wa == mmpio_pkg::OFF_PINS);

    mmpio_pkg::mmpio_cmd_t cmd;
    assign cmd = s_axi_wdata;
    wire mmpio_pkg::mmpio_op_t op = mmpio_pkg::mmpio_op_t'(cmd.op);

    wire        c_bidir   = (cmd.port == mmpio_pkg::PORT2) || (cmd.port == mmpio_pkg::PORT3) ||
                            (cmd.port == mmpio_pkg::PORT5) || (cmd.port == mmpio_pkg::PORT6);
    wire        c_valid   = c_bidir || (cmd.port == mmpio_pkg::PORT0) ||
                            (cmd.port == mmpio_pkg::PORT1);
    // A command needs its low three byte lanes, otherwise it would run on stale fields.
    wire        cmd_full  = s_axi_wstrb[0] && s_axi_wstrb[1] && s_axi_wstrb[2];
    wire        cmd_fire  = wr_take && hit_cmd && cmd_full && c_valid;
    wire        wr_err    = !(hit_dir_a || hit_dir_b || wa_ro || (hit_cmd && c_valid));

    wire [3:0]  c_pin     = (cmd.port == mmpio_pkg::PORT0) ? pin_in.p0 :
                            (cmd.port == mmpio_pkg::PORT1) ? (pin_in.p1 & mmpio_pkg::P1_MASK) :
                            (cmd.port == mmpio_pkg::PORT2) ? pin_in.p2 :
                            (cmd.port == mmpio_pkg::PORT3) ? pin_in.p3 :
                            (cmd.port == mmpio_pkg::PORT5) ? pin_in.p5 : pin_in.p6;
    wire [1:0]  c_slot    = slot_of(cmd.port);
    wire [3:0]  c_dir     = port_dir(cmd.port, dir_a, dir_b);
    wire [3:0]  c_latch   = c_bidir ? latch[c_slot] : mmpio_pkg::NIB_ZERO;
    wire [3:0]  c_rd      = (c_dir & c_latch) | (~c_dir & c_pin);
    wire [3:0]  c_onehot  = mmpio_pkg::NIB_ONE << cmd.bit_sel;
    wire        c_tbit    = c_rd[cmd.bit_sel];
    wire [3:0]  c_inc     = 4'(c_rd + mmpio_pkg::NIB_ONE);

    always_comb begin
        next_latch         = c_latch;
        latch_we           = 1'b0;
        next_result        = '0;
        next_result.data   = c_rd;
        next_result.test   = c_tbit;
        next_result.carry  = cmd.carry;
        case (op)
            mmpio_pkg::OP_READ: next_result.data = c_rd;
            mmpio_pkg::OP_WRITE, mmpio_pkg::OP_EXCH: begin
                next_latch = cmd.acc;
                latch_we   = 1'b1;
            end
            mmpio_pkg::OP_INCREMENT_SKIP_INSTRUCTION: begin
                next_latch       = c_inc;
                latch_we         = 1'b1;
                next_result.skip = (c_inc == mmpio_pkg::NIB_ZERO);
            end
            mmpio_pkg::OP_SET: begin
                next_latch = c_rd | c_onehot;
                latch_we   = 1'b1;
            end
            mmpio_pkg::OP_CLR: begin
                next_latch = c_rd & ~c_onehot;
                latch_we   = 1'b1;
            end
            mmpio_pkg::OP_TCLR: begin
                next_latch       = c_rd & ~c_onehot;
                latch_we         = 1'b1;
                next_result.skip = c_tbit;
            end
            mmpio_pkg::OP_SKT: next_result.skip = c_tbit;
            mmpio_pkg::OP_SKF: next_result.skip = !c_tbit;
            mmpio_pkg::OP_AND: next_result.carry = cmd.carry & c_tbit;
            mmpio_pkg::OP_OR:  next_result.carry = cmd.carry | c_tbit;
            mmpio_pkg::OP_XOR: next_result.carry = cmd.carry ^ c_tbit;
            default: next_result = result_q;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_a <= mmpio_pkg::DIR_RST;
            dir_b <= mmpio_pkg::DIR_RST;
        end else if (wr_take && s_axi_wstrb[0]) begin
            if (hit_dir_a) dir_a <= s_axi_wdata[7:0];
            if (hit_dir_b) dir_b <= s_axi_wdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_q <= '0;
        end else if (cmd_fire) begin
            result_q <= next_result;
        end
    end

    logic [15:0] out_vec;
    logic [15:0] oe_vec;

    // Latches of ports 2, 3, 5 and 6 live in slots 0 to 3.
    for (genvar g = 0; g < mmpio_pkg::SLOTS; g++) begin : g_slot
        wire [3:0] sd = port_dir(mmpio_pkg::SLOT_PORT[g], dir_a, dir_b);
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                latch[g] <= mmpio_pkg::LATCH_RST;
            end else if (cmd_fire && latch_we && c_bidir && c_slot == g) begin
                latch[g] <= next_latch;
            end
        end
        if (g == mmpio_pkg::SLOT_P5) begin : g_od
            // Open-drain port only pulls low; a latched one releases the pin.
            assign out_vec[g*4 +: 4] = mmpio_pkg::NIB_ZERO;
            assign oe_vec[g*4 +: 4]  = ~(sd & ~latch[g]);
        end else begin : g_pp
            assign out_vec[g*4 +: 4] = latch[g];
            assign oe_vec[g*4 +: 4]  = ~sd;
        end
    end

    assign pin_out  = out_vec;
    assign pin_oe_n = oe_vec;

    wire [31:0] rd_mux = (ra == mmpio_pkg::OFF_DIR_A)  ? {24'h000000, dir_a} :
                         (ra == mmpio_pkg::OFF_DIR_B)  ? {24'h000000, dir_b} :
                         (ra == mmpio_pkg::OFF_RESULT) ? 32'(result_q) :
                         (ra == mmpio_pkg::OFF_LATCH)  ? {16'h0000, latch[3], latch[2],
                                                          latch[1], latch[0]} :
                         (ra == mmpio_pkg::OFF_PINS)   ? {8'h00, pin_in} : 32'h00000000;
    wire        rd_ok  = (ra == mmpio_pkg::OFF_DIR_A) || (ra == mmpio_pkg::OFF_DIR_B) ||
                         (ra == mmpio_pkg::OFF_RESULT) || (ra == mmpio_pkg::OFF_LATCH) ||
                         (ra == mmpio_pkg::OFF_PINS) || (ra == mmpio_pkg::OFF_CMD);

    assign s_axi_awready = wr_take;
    assign s_axi_wready  = wr_take;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= mmpio_pkg::RESP_OKAY;
        end else if (wr_take) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_err ? mmpio_pkg::RESP_SLVERR : mmpio_pkg::RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= mmpio_pkg::RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_ok ? mmpio_pkg::RESP_OKAY : mmpio_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    wire is_wr   = cmd_fire && c_bidir && (op == mmpio_pkg::OP_WRITE);
    wire is_exch = cmd_fire && c_bidir && (op == mmpio_pkg::OP_EXCH);
    wire is_increment_skip_instruction = cmd_fire && c_bidir && (op == mmpio_pkg::OP_INCREMENT_SKIP_INSTRUCTION);

    chk_dir_drives_pins: assert property (
        pin_oe_n.p3 == ~dir_a[3:0] && pin_oe_n.p6 == ~dir_a[7:4])
        else $error("Port three or six enable does not follow direction.");
    chk_nibble_dir_p2: assert property (
        pin_oe_n.p2 == {4{!dir_b[mmpio_pkg::DIRB_P2_BIT]}})
        else $error("Port two enable does not follow its group bit.");
    chk_reset_state: assert property (
        $rose(rst_n) |-> dir_a == mmpio_pkg::DIR_RST && latch[1] == mmpio_pkg::LATCH_RST)
        else $error("Direction or latch not cleared by reset.");
    chk_write_latch: assert property (
        is_wr |=> latch[$past(c_slot)] == $past(cmd.acc) && $stable(dir_a))
        else $error("Nibble write did not load the latch.");
    chk_exch_swap: assert property (
        is_exch |=> latch[$past(c_slot)] == $past(cmd.acc) && result_q.data == $past(c_rd))
        else $error("Exchange did not swap latch and accumulator.");
    chk_increment_skip_instruction_value: assert property (
        is_increment_skip_instruction |=> latch[$past(c_slot)] == 4'($past(c_rd) + mmpio_pkg::NIB_ONE))
        else $error("Increment did not load the read value plus one.");
    chk_read_source: assert property (
        cmd_fire && op == mmpio_pkg::OP_READ |=>
        result_q.data == (($past(c_dir) & $past(c_latch)) | (~$past(c_dir) & $past(c_pin))))
        else $error("Read returned the wrong source.");
    chk_carry_and: assert property (
        cmd_fire && op == mmpio_pkg::OP_AND |=> result_q.carry == ($past(cmd.carry) & $past(c_tbit)))
        else $error("Carry AND used the wrong bit.");
    chk_bit_test: assert property (
        cmd_fire && op == mmpio_pkg::OP_SKT |=> result_q.skip == $past(c_tbit))
        else $error("Bit test skip is wrong.");
    chk_input_only_read: assert property (
        cmd_fire && cmd.port == mmpio_pkg::PORT0 && op == mmpio_pkg::OP_READ |=>
        result_q.data == $past(pin_in.p0))
        else $error("Port zero read did not return pins.");
    chk_bit_set_only: assert property (
        cmd_fire && c_bidir && op == mmpio_pkg::OP_SET && c_dir == mmpio_pkg::NIB_ALL |=>
        latch[$past(c_slot)] == ($past(c_latch) | $past(c_onehot)))
        else $error("Output-mode bit set touched other bits.");
    chk_tclr_clears_bit: assert property (
        cmd_fire && c_bidir && op == mmpio_pkg::OP_TCLR |=>
        latch[$past(c_slot)][$past(cmd.bit_sel)] == 1'b0)
        else $error("Test-and-clear left the addressed bit set.");
    chk_increment_skip_instruction_pins: assert property (
        is_increment_skip_instruction && c_dir == mmpio_pkg::NIB_ZERO |=>
        latch[$past(c_slot)] == 4'($past(c_pin) + mmpio_pkg::NIB_ONE))
        else $error("Input-mode increment did not load pins plus one.");

    cov_exch_output: cover property (is_exch && c_dir == mmpio_pkg::NIB_ALL);
    cov_increment_skip_instruction_wrap:   cover property (is_increment_skip_instruction && c_inc == mmpio_pkg::NIB_ZERO);
    cov_tclr_skip:   cover property (cmd_fire && op == mmpio_pkg::OP_TCLR && c_tbit);
    cov_read_output: cover property (cmd_fire && op == mmpio_pkg::OP_READ &&
                                     c_dir == mmpio_pkg::NIB_ALL);

endmodule : mmpio_port_io

//--- include/mmpio_pkg.sv
// Purpose: Shared constants and types for the memory-mapped port I/O block.
// Assumes: AXI4-Lite register access with 32-bit data and 8-bit byte addresses.
// Notes:   Each register takes one aligned word; unused upper bits read as zero.
package mmpio_pkg;

    localparam int          ADDR_W      = 8;
    localparam logic [7:0]  OFF_DIR_A   = 8'h00;
    localparam logic [7:0]  OFF_DIR_B   = 8'h04;
    localparam logic [7:0]  OFF_CMD     = 8'h08;
    localparam logic [7:0]  OFF_RESULT  = 8'h0C;
    localparam logic [7:0]  OFF_LATCH   = 8'h10;
    localparam logic [7:0]  OFF_PINS    = 8'h14;

    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    localparam logic [7:0]  DIR_RST     = 8'h00;
    localparam logic [3:0]  LATCH_RST   = 4'h0;
    localparam logic [3:0]  NIB_ONE     = 4'h1;
    localparam logic [3:0]  NIB_ALL     = 4'hF;
    localparam logic [3:0]  NIB_ZERO    = 4'h0;

    // Group B carries one whole-nibble direction bit for each of ports two and five.
    localparam int          DIRB_P2_BIT = 2;
    localparam int          DIRB_P5_BIT = 5;
    localparam int          DIRA_P3_LSB = 0;
    localparam int          DIRA_P6_LSB = 4;

    // Port one has pins only on bits 0 and 2; port instructions read the others as zero, OFF_PINS reads them unmasked.
    localparam logic [3:0]  P1_MASK     = 4'h5;

    localparam logic [2:0]  PORT0       = 3'h0;
    localparam logic [2:0]  PORT1       = 3'h1;
    localparam logic [2:0]  PORT2       = 3'h2;
    localparam logic [2:0]  PORT3       = 3'h3;
    localparam logic [2:0]  PORT5       = 3'h5;
    localparam logic [2:0]  PORT6       = 3'h6;

    localparam int          SLOTS       = 4;
    localparam int          SLOT_P5     = 2;
    localparam logic [2:0]  SLOT_PORT [SLOTS] = '{PORT2, PORT3, PORT5, PORT6};

    typedef enum logic [3:0] {
        OP_READ, OP_WRITE, OP_EXCH, OP_INCREMENT_SKIP_INSTRUCTION, OP_SET, OP_CLR, OP_TCLR,
        OP_SKT, OP_SKF, OP_AND, OP_OR, OP_XOR
    } mmpio_op_t;

    typedef struct packed {
        logic [14:0] unused;
        logic        carry;
        logic [1:0]  rsv_b;
        logic [1:0]  bit_sel;
        logic        rsv_a;
        logic [2:0]  port;
        logic [3:0]  op;
        logic [3:0]  acc;
    } mmpio_cmd_t;

    typedef struct packed {
        logic [24:0] unused;
        logic        skip;
        logic        carry;
        logic        test;
        logic [3:0]  data;
    } mmpio_result_t;

    typedef struct packed {
        logic [3:0] p6;
        logic [3:0] p5;
        logic [3:0] p3;
        logic [3:0] p2;
        logic [3:0] p1;
        logic [3:0] p0;
    } mmpio_pin_in_t;

    typedef struct packed {
        logic [3:0] p6;
        logic [3:0] p5;
        logic [3:0] p3;
        logic [3:0] p2;
    } mmpio_pin_out_t;

endpackage : mmpio_pkg

//--- test/mmpio_pin_model.sv
// Purpose: External circuits attached to the port pins.
// Assumes: Each pin shows the block's drive where enabled, else an outside level.
// Notes:   Port five is open drain, so a driven bit can only pull the line low.
`timescale 1ns/1ns
module mmpio_pin_model (
    input  wire mmpio_pkg::mmpio_pin_out_t pin_out,
    input  wire mmpio_pkg::mmpio_pin_out_t pin_oe_n,
    input  wire mmpio_pkg::mmpio_pin_in_t  ext,
    output mmpio_pkg::mmpio_pin_in_t       pin_in
);
    wire [15:0] outside;
    wire [15:0] driven;
    wire [3:0]  drain;

    assign outside = {ext.p6, ext.p5, ext.p3, ext.p2};
    // buffer off: undriven pins show the outside level, not the latch.
    assign driven = (pin_oe_n & outside) | (~pin_oe_n & pin_out);
    // open drain: an enabled bit pulls low whatever the latch says.
    assign drain = pin_oe_n.p5 & ext.p5;
    // input ports: always the outside level.
    assign pin_in = {driven[15:12], drain, driven[7:0], ext.p1, ext.p0};
endmodule : mmpio_pin_model

//--- test/memory_mapped_port_io_logic_tb.sv
// Purpose: Self-checking bench for the memory-mapped port block over its register bus.
// Assumes: Results and latches are visible one cycle after the write handshake.
// Notes:   Input-mode bit writes expect the other latch bits to take the pin levels.
`timescale 1ns/1ns
module memory_mapped_port_io_logic_tb;
    logic                      clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic                      arvalid, arready, rvalid, rready;
    logic [7:0]                awaddr, araddr;
    logic [31:0]               wdata, rdata, res;
    logic [3:0]                wstrb;
    logic [1:0]                bresp, rresp;
    mmpio_pkg::mmpio_pin_in_t  pin_in, ext;
    mmpio_pkg::mmpio_pin_out_t pin_out, pin_oe_n;
    int                        fail_count, checked;

    mmpio_port_io uut (.clk(clk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));

    mmpio_pin_model pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext(ext), .pin_in(pin_in));

    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask : chk

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        do @(posedge clk); while (!(awready && wready));
        awvalid <= 1'h0;
        wvalid <= 1'h0;
        bready <= 1'h1;
        do @(posedge clk); while (!bvalid);
        bready <= 1'h0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'h0;
        rready <= 1'h1;
        do @(posedge clk); while (!rvalid);
        rready <= 1'h0;
        d = rdata;
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    endtask : axi_rd

    task automatic rd_chk(input string n, input logic [7:0] a, input logic [1:0] er,
                          input logic [31:0] exp);
        logic [31:0] d;
        axi_rd(a, er, d);
        chk(n, exp, d);
    endtask : rd_chk

    task automatic exec(input mmpio_pkg::mmpio_op_t op, input logic [2:0] port,
                        input logic [1:0] b, input logic [3:0] acc, input logic cy);
        mmpio_pkg::mmpio_cmd_t c;
        c = '0;
        c.op = op;
        c.port = port;
        c.bit_sel = b;
        c.acc = acc;
        c.carry = cy;
        axi_wr(mmpio_pkg::OFF_CMD, c, mmpio_pkg::RESP_OKAY);
        axi_rd(mmpio_pkg::OFF_RESULT, mmpio_pkg::RESP_OKAY, res);
    endtask : exec

    task automatic run(input mmpio_pkg::mmpio_op_t op, input logic [2:0] port,
                       input logic [1:0] b, input logic [3:0] acc, input logic [3:0] exp);
        exec(op, port, b, acc, 1'h0);
        chk("result data", {28'h0, exp}, {28'h0, res[3:0]});
    endtask : run

    task automatic flag(input mmpio_pkg::mmpio_op_t op, input logic [2:0] port,
                        input logic [1:0] b, input logic cy, input int idx, input logic exp);
        exec(op, port, b, 4'h0, cy);
        chk("result flag", {31'h0, exp}, {31'h0, res[idx]});
    endtask : flag

    task automatic latch(input logic [15:0] exp);
        rd_chk("latch", mmpio_pkg::OFF_LATCH, mmpio_pkg::RESP_OKAY, {16'h0, exp});
    endtask : latch

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    // The whole sequence needs well under a thousand cycles.
    initial begin
        #(5000 * 100);
        fail_count++;
        end_of_test();
    end

    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'hF;
        rst_n = 1'h0;
        ext = 24'h0F3AF9;
        repeat (6) @(posedge clk);
        rst_n <= 1'h1;
        rd_chk("dir a", mmpio_pkg::OFF_DIR_A, mmpio_pkg::RESP_OKAY, 32'h0);
        rd_chk("dir b", mmpio_pkg::OFF_DIR_B, mmpio_pkg::RESP_OKAY, 32'h0);
        chk("oe_n", 32'hFFFF, {16'h0, pin_oe_n});
        axi_wr(mmpio_pkg::OFF_LATCH, 32'hFFFF, mmpio_pkg::RESP_OKAY);
        latch(16'h0);
        axi_wr(8'h3C, 32'h0, mmpio_pkg::RESP_SLVERR);
        rd_chk("unmapped", 8'h3C, mmpio_pkg::RESP_SLVERR, 32'h0);
        axi_wr(mmpio_pkg::OFF_CMD, 32'h400, mmpio_pkg::RESP_SLVERR);
        // Port two in input mode, pins at A.
        run(mmpio_pkg::OP_READ, mmpio_pkg::PORT2, 2'h0, 4'h0, 4'hA);
        run(mmpio_pkg::OP_WRITE, mmpio_pkg::PORT2, 2'h0, 4'h5, 4'hA);
        latch(16'h0005);
        chk("oe_n", 32'hFFFF, {16'h0, pin_oe_n});
        run(mmpio_pkg::OP_INCREMENT_SKIP_INSTRUCTION, mmpio_pkg::PORT2, 2'h0, 4'h0, 4'hA);
        latch(16'h000B);
        run(mmpio_pkg::OP_EXCH, mmpio_pkg::PORT2, 2'h0, 4'h3, 4'hA);
        latch(16'h0003);
        run(mmpio_pkg::OP_SET, mmpio_pkg::PORT2, 2'h0, 4'h0, 4'hA);
        latch(16'h000B);
        run(mmpio_pkg::OP_WRITE, mmpio_pkg::PORT2, 2'h0, 4'hE, 4'hA);
        // Port two in output mode.
        axi_wr(mmpio_pkg::OFF_DIR_B, 32'h4, mmpio_pkg::RESP_OKAY);
        chk("out p2", 32'hE, {28'h0, pin_out.p2});
        chk("oe_n p2", 32'h0, {28'h0, pin_oe_n.p2});
        run(mmpio_pkg::OP_READ, mmpio_pkg::PORT2, 2'h0, 4'h0, 4'hE);
        run(mmpio_pkg::OP_WRITE, mmpio_pkg::PORT2, 2'h0, 4'h7, 4'hE);
        chk("out p2", 32'h7, {28'h0, pin_out.p2});
        run(mmpio_pkg::OP_EXCH, mmpio_pkg::PORT2, 2'h0, 4'h2, 4'h7);
        chk("out p2", 32'h2, {28'h0, pin_out.p2});
        run(mmpio_pkg::OP_SET, mmpio_pkg::PORT2, 2'h3, 4'h0, 4'h2);
        chk("out p2", 32'hA, {28'h0, pin_out.p2});
        run(mmpio_pkg::OP_INCREMENT_SKIP_INSTRUCTION, mmpio_pkg::PORT2, 2'h0, 4'h0, 4'hA);
        chk("out p2", 32'hB, {28'h0, pin_out.p2});
        run(mmpio_pkg::OP_WRITE, mmpio_pkg::PORT2, 2'h0, 4'hF, 4'hB);
        flag(mmpio_pkg::OP_INCREMENT_SKIP_INSTRUCTION, mmpio_pkg::PORT2, 2'h0, 1'h0, 6, 1'h1);
        chk("out p2", 32'h0, {28'h0, pin_out.p2});
        // Port three mixed per bit, pins at 3.
        run(mmpio_pkg::OP_WRITE, mmpio_pkg::PORT3, 2'h0, 4'hC, 4'h3);
        axi_wr(mmpio_pkg::OFF_DIR_A, 32'h05, mmpio_pkg::RESP_OKAY);
        chk("oe_n p3", 32'hA, {28'h0, pin_oe_n.p3});
        run(mmpio_pkg::OP_READ, mmpio_pkg::PORT3, 2'h0, 4'h0, 4'h6);
        axi_wr(mmpio_pkg::OFF_DIR_A, 32'hF5, mmpio_pkg::RESP_OKAY);
        chk("oe_n p6", 32'h0, {28'h0, pin_oe_n.p6});
        // Port five open drain, outside level high.
        run(mmpio_pkg::OP_WRITE, mmpio_pkg::PORT5, 2'h0, 4'h5, 4'hF);
        axi_wr(mmpio_pkg::OFF_DIR_B, 32'h24, mmpio_pkg::RESP_OKAY);
        chk("oe_n p5", 32'h5, {28'h0, pin_oe_n.p5});
        run(mmpio_pkg::OP_READ, mmpio_pkg::PORT5, 2'h0, 4'h0, 4'h5);
        run(mmpio_pkg::OP_READ, mmpio_pkg::PORT0, 2'h0, 4'h0, 4'h9);
        run(mmpio_pkg::OP_READ, mmpio_pkg::PORT1, 2'h0, 4'h0, 4'h5);
        flag(mmpio_pkg::OP_AND, mmpio_pkg::PORT0, 2'h0, 1'h1, 5, 1'h1);
        flag(mmpio_pkg::OP_OR, mmpio_pkg::PORT0, 2'h1, 1'h0, 5, 1'h0);
        flag(mmpio_pkg::OP_XOR, mmpio_pkg::PORT0, 2'h3, 1'h1, 5, 1'h0);
        flag(mmpio_pkg::OP_AND, mmpio_pkg::PORT2, 2'h1, 1'h1, 5, 1'h0);
        flag(mmpio_pkg::OP_SKT, mmpio_pkg::PORT0, 2'h3, 1'h0, 6, 1'h1);
        flag(mmpio_pkg::OP_SKF, mmpio_pkg::PORT0, 2'h3, 1'h0, 6, 1'h0);
        run(mmpio_pkg::OP_SET, mmpio_pkg::PORT2, 2'h2, 4'h0, 4'h0);
        flag(mmpio_pkg::OP_TCLR, mmpio_pkg::PORT2, 2'h2, 1'h0, 6, 1'h1);
        chk("out p2", 32'h0, {28'h0, pin_out.p2});
        // An unused operation code must leave the last result in place.
        axi_wr(mmpio_pkg::OFF_CMD, 32'h000000C2, mmpio_pkg::RESP_OKAY);
        rd_chk("result kept", mmpio_pkg::OFF_RESULT, mmpio_pkg::RESP_OKAY, 32'h54);
        // A second reset in mid-run.
        @(posedge clk);
        rst_n <= 1'h0;
        repeat (2) @(posedge clk);
        chk("oe_n", 32'hFFFF, {16'h0, pin_oe_n});
        rst_n <= 1'h1;
        latch(16'h0);
        end_of_test();
    end
endmodule : memory_mapped_port_io_logic_tb
